// *** core/svm_ctrl.sv ***
// Function
// - Reset mode holds reset while supply low
// - Interrupt mode pulses on both crossings
// - Control bit 0 reads below-level flag
// - Control bit 7 enables the comparator
// - Own reset keeps enable and mode
// - Default start holds reset below fixed level
// - Level bits 3..0 pick eleven thresholds
// - Level register survives own reset only
// - Flag sets after minimum low pulse
// - Disabling while low in interrupt mode raises an interrupt
// - Own reset sets reset-cause bit 0
// - Every reset sets the interrupt mask
`timescale 1ns/100ps
`default_nettype none
module svm_ctrl #(
	parameter int PULSE_CYC = svm_pkg::MIN_PULSE_CYC
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Device reset source and option
	input  wire logic [1:0]  reset_source,
	input  wire logic        default_start_option,
	// Register port
	input  wire logic [15:0] addr,
	input  wire logic        wr_en,
	input  wire logic        bit_wr,
	input  wire logic [2:0]  bit_sel,
	input  wire logic [7:0]  wr_data,
	input  wire logic        rd_en,
	output logic [7:0]       rd_data,
	// Analog comparator
	input  wire logic        comp_below,
	output logic             comp_on,
	output logic [3:0]       comp_level,
	output logic             level_reserved,
	// Reset and interrupt
	output logic             supply_reset,
	output logic             supply_irq,
	output logic             supply_irq_mask,
	output logic             lowsupply_reset_cause,
	output logic             reset_by_default
);
	//////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers
	logic [1:0] rst_sync_reg;
	logic       srst_n;
	logic [1:0] comp_sync_reg;

	// Release the reset through two flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign srst_n = rst_sync_reg[1];

	// Comparator output comes from the analog side
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			comp_sync_reg <= 2'b00;
		end else begin
			comp_sync_reg <= {comp_sync_reg[0], comp_below};
		end
	end

	//////////////////////////////////////////////////////////////////
	// Filter
	svm_filter_if fif ();
	logic         on_reg;
	logic         default_on;

	svm_filter #(.PULSE_CYC(PULSE_CYC)) u_filter (
		.clk   (mclk),
		.rst_n (srst_n),
		.fi    (fif.filter)
	);
	assign fif.raw_below = comp_sync_reg[1];
	assign fif.enable    = on_reg | default_on;

	//////////////////////////////////////////////////////////////////
	// Registers
	logic       on_next;
	logic       mode_reg;
	logic       mode_next;
	logic [3:0] level_reg;
	logic [3:0] level_next;
	logic       cause_reg;
	logic       cause_next;
	logic       cause_hold_reg;
	logic       dflt_reg;
	logic       dflt_next;
	logic       mask_reg;
	logic       mask_next;
	logic       rst_out_reg;
	logic       rst_out_next;
	logic       irq_reg;
	logic       irq_next;
	logic       below_d_reg;
	logic       below_d_next;
	logic [7:0] rd_reg;
	logic [7:0] rd_next;
	logic       opt_reg;
	logic       started_reg;
	logic       ctrl_sel;
	logic       level_sel;
	logic [7:0] ctrl_view;
	logic [7:0] ctrl_wr;
	logic [7:0] level_view;
	logic [7:0] level_wr;

	// Default start runs until software takes over with its own enable
	assign default_on = opt_reg & started_reg & ~on_reg;
	assign ctrl_sel   = (addr == svm_pkg::CTRL_ADDR);
	assign level_sel  = (addr == svm_pkg::LEVEL_ADDR);
	// Unused bits read zero
	assign ctrl_view  = {on_reg, 5'b0_0000, mode_reg, fif.below};
	assign level_view = {4'h0, level_reg};

	// Merge byte or single-bit writes
	always_comb begin
		ctrl_wr  = ctrl_view;
		level_wr = level_view;
		if (bit_wr) begin
			ctrl_wr[bit_sel]  = wr_data[0];
			level_wr[bit_sel] = wr_data[0];
		end else begin
			ctrl_wr  = wr_data;
			level_wr = wr_data;
		end
	end

	// Next register and output values
	always_comb begin
		on_next      = on_reg;
		mode_next    = mode_reg;
		level_next   = level_reg;
		cause_next   = cause_reg;
		dflt_next    = dflt_reg;
		mask_next    = mask_reg;
		below_d_next = fif.below;
		irq_next     = 1'b0;
		rd_next      = rd_reg;
		if (wr_en && ctrl_sel) begin
			on_next   = ctrl_wr[svm_pkg::CTRL_ON_BIT];
			mode_next = ctrl_wr[svm_pkg::CTRL_MODE_BIT];
		end
		if (wr_en && level_sel) begin
			level_next = level_wr[3:0];
		end
		if (rd_en) begin
			rd_next = ctrl_sel ? ctrl_view : (level_sel ? level_view : 8'h00);
		end
		// Interrupt on either crossing while enabled in interrupt mode
		if (on_reg && !mode_reg && (fif.below != below_d_reg)) begin
			irq_next = 1'b1;
		end
		// Turning off while low also raises a request
		if (on_reg && !on_next && !mode_reg && comp_sync_reg[1]) begin
			irq_next = 1'b1;
		end
		// Reset while low in reset mode, or under default start
		rst_out_next = (on_reg && mode_reg && fif.below)
			|| (default_on && fif.below);
		if (rst_out_next && !rst_out_reg) begin
			cause_next = 1'b1;
			dflt_next  = default_on && !(on_reg && mode_reg);
		end
	end

	// Capture the default start option once after release
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			opt_reg     <= 1'b0;
			started_reg <= 1'b0;
		end else if (!started_reg) begin
			opt_reg     <= default_start_option;
			started_reg <= 1'b1;
		end
	end

	// Status registers; every reset sets the mask and clears all the others
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			rd_reg      <= svm_pkg::CTRL_RESET;
			mask_reg    <= 1'b1;
			rst_out_reg <= 1'b0;
			irq_reg     <= 1'b0;
			below_d_reg <= 1'b0;
			dflt_reg    <= 1'b0;
			cause_reg   <= 1'b0;
		end else begin
			rd_reg      <= rd_next;
			mask_reg    <= started_reg ? mask_next : 1'b1;
			rst_out_reg <= rst_out_next;
			irq_reg     <= irq_next;
			below_d_reg <= below_d_next;
			dflt_reg    <= dflt_next;
			cause_reg   <= cause_next;
		end
	end

	// Keep enable, mode and level across own non-default resets
	always_ff @(posedge mclk) begin
		if (!started_reg) begin
			if (reset_source != 2'(svm_pkg::SVM_RST_OWN)) begin
				on_reg    <= svm_pkg::CTRL_RESET[svm_pkg::CTRL_ON_BIT];
				mode_reg  <= svm_pkg::CTRL_RESET[svm_pkg::CTRL_MODE_BIT];
				level_reg <= svm_pkg::LEVEL_RESET[3:0];
			end
			if (reset_source == 2'(svm_pkg::SVM_RST_OTHER)) begin
				cause_hold_reg <= 1'b0;
			end else if (reset_source == 2'(svm_pkg::SVM_RST_OWN)) begin
				cause_hold_reg <= 1'b1;
			end else begin
				cause_hold_reg <= 1'b0;
			end
		end else begin
			on_reg    <= on_next;
			mode_reg  <= mode_next;
			level_reg <= level_next;
			if (cause_reg) begin
				cause_hold_reg <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// Outputs
	logic [3:0] lvl_out_reg;
	logic       on_out_reg;
	logic       resv_reg;

	// Comparator controls straight from flops
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			on_out_reg  <= 1'b0;
			lvl_out_reg <= svm_pkg::LEVEL_DEFAULT;
			resv_reg    <= 1'b0;
		end else begin
			on_out_reg  <= on_next | default_on;
			lvl_out_reg <= default_on ? svm_pkg::LEVEL_DEFAULT : level_next;
			resv_reg    <= level_next > svm_pkg::LEVEL_MAX_CODE;
		end
	end

	assign comp_on               = on_out_reg;
	assign comp_level            = lvl_out_reg;
	assign level_reserved        = resv_reg;
	assign rd_data               = rd_reg;
	assign supply_reset          = rst_out_reg;
	assign supply_irq            = irq_reg;
	assign supply_irq_mask       = mask_reg;
	assign lowsupply_reset_cause = cause_hold_reg;
	assign reset_by_default      = dflt_reg;
endmodule : svm_ctrl
`default_nettype wire

// *** core/svm_filter.sv ***
`timescale 1ns/100ps
`default_nettype none
// Qualifies a falling supply over a least pulse width; rising clears at once
module svm_filter #(
	parameter int PULSE_CYC = svm_pkg::MIN_PULSE_CYC
) (
	// Clock and reset
	input wire logic    clk,
	input wire logic    rst_n,
	// Comparator side
	svm_filter_if.filter fi
);
	logic [svm_pkg::PULSE_CNT_W-1:0] cnt_reg;
	logic [svm_pkg::PULSE_CNT_W-1:0] cnt_next;
	logic                            below_reg;
	logic                            below_next;

	// Count how long the supply has stayed under the level
	always_comb begin
		cnt_next   = cnt_reg;
		below_next = below_reg;
		if (!fi.enable || !fi.raw_below) begin
			cnt_next   = '0;
			below_next = 1'b0;
		end else if (cnt_reg >= svm_pkg::PULSE_CNT_W'(PULSE_CYC - 1)) begin
			below_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg   <= '0;
			below_reg <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			below_reg <= below_next;
		end
	end

	assign fi.below = below_reg;
endmodule : svm_filter
`default_nettype wire

// *** core/svm_filter_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// Carries the synchronised comparator level and the filtered result
interface svm_filter_if;
	logic raw_below;
	logic enable;
	logic below;
	modport owner (output raw_below, output enable, input below);
	modport filter (input raw_below, input enable, output below);
endinterface : svm_filter_if
`default_nettype wire

// *** core/svm_pkg.sv ***
package svm_pkg;
	// Register addresses
	localparam logic [15:0] CTRL_ADDR      = 16'hFFBE;
	localparam logic [15:0] LEVEL_ADDR     = 16'hFFBF;
	// Field positions and reset values
	localparam int          CTRL_ON_BIT    = 7;
	localparam int          CTRL_MODE_BIT  = 1;
	localparam int          CTRL_FLAG_BIT  = 0;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  LEVEL_RESET    = 8'h00;
	localparam logic [3:0]  LEVEL_DEFAULT  = 4'hA;
	localparam logic [3:0]  LEVEL_MAX_CODE = 4'hA;
	// Timing
	localparam int          CLK_MHZ        = 25;
	localparam int          MIN_PULSE_US   = 200;
	localparam int          MIN_PULSE_CYC  = MIN_PULSE_US * CLK_MHZ;
	localparam int          PULSE_CNT_W    = 13;
	// Sources of the device reset
	typedef enum logic [1:0] {
		SVM_RST_OTHER,
		SVM_RST_OWN,
		SVM_RST_DEFAULT
	} svm_rst_src_t;
endpackage : svm_pkg

// *** tb/svm_comp_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Supply comparator model: flags a supply under the selected threshold
module svm_comp_model (
	// Monitor settings
	input wire logic        comp_on,
	input wire logic [3:0]  comp_level,
	// Supply in millivolts, set by the bench
	input wire logic [12:0] supply_mv,
	// Comparator result
	output logic            comp_below
);
	localparam logic [12:0] TH [11] = '{13'h1090, 13'h0FFA, 13'h0F5A, 13'h0EC4, 13'h0E24,
		13'h0D8E, 13'h0CF8, 13'h0C58, 13'h0BC2, 13'h0B22, 13'h0A8C};
	// Threshold per code; reserved codes give no level
	function automatic logic [12:0] thr(input logic [3:0] c);
		return (c <= 4'hA) ? TH[c] : 13'h0000;
	endfunction : thr
	// Ignores comp_on, so the block itself must mask a disabled comparator
	assign comp_below = (supply_mv < thr(comp_level));
endmodule : svm_comp_model
`default_nettype wire

// *** tb/svm_ctrl_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module svm_ctrl_props #(parameter int PULSE_CYC = 8) (
	// Clock, reset, option
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        default_start_option,
	// Register port
	input wire logic [15:0] addr,
	input wire logic        wr_en,
	input wire logic        bit_wr,
	input wire logic [7:0]  wr_data,
	input wire logic        rd_en,
	input wire logic [7:0]  rd_data,
	// Comparator, reset and interrupt
	input wire logic        comp_below,
	input wire logic        comp_on,
	input wire logic [3:0]  comp_level,
	input wire logic        level_reserved,
	input wire logic        supply_reset,
	input wire logic        supply_irq,
	input wire logic        supply_irq_mask
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [15:0] low_cnt;
	// Cycles the comparator has reported a low supply in a row
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			low_cnt <= 16'h0000;
		else
			low_cnt <= comp_below ? low_cnt + {15'h0000, low_cnt != 16'hFFFF} : 16'h0000;
	end
	property p_mask; $rose(rst_n) |-> supply_irq_mask; endproperty
	property p_pulse; supply_irq |=> !supply_irq; endproperty
	property p_unmap; rd_en && addr != 16'hFFBE && addr != 16'hFFBF |=> rd_data == 8'h00;
	endproperty
	property p_on; wr_en && !bit_wr && addr == 16'hFFBE && !default_start_option
		|=> comp_on == $past(wr_data[7]); endproperty
	property p_lvl; wr_en && !bit_wr && addr == 16'hFFBF && !default_start_option
		|=> comp_level == $past(wr_data[3:0]); endproperty
	property p_filt; $rose(supply_reset) && !default_start_option |-> low_cnt >= PULSE_CYC;
	endproperty
	// Two sync flops, the filter flop and the output flop lie between
	property p_rel; (!comp_below) [*5] |-> !supply_reset; endproperty
	property p_resv; level_reserved == (comp_level > 4'hA); endproperty
	a_mask: assert property (p_mask) else $error("mask clear after reset");
	a_pulse: assert property (p_pulse) else $error("irq longer than a cycle");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_on: assert property (p_on) else $error("enable not written");
	a_lvl: assert property (p_lvl) else $error("level not written");
	a_filt: assert property (p_filt) else $error("reset before pulse width");
	a_rel: assert property (p_rel) else $error("reset held with supply high");
	a_resv: assert property (p_resv) else $error("reserved code flag wrong");
	c_rst: cover property ($rose(supply_reset));
	c_irq: cover property (supply_irq);
	c_resv: cover property (level_reserved);
endmodule : svm_ctrl_props
bind svm_ctrl svm_ctrl_props #(.PULSE_CYC(PULSE_CYC)) svm_ctrl_props_inst (.mclk(mclk),
	.rst_n(rst_n), .default_start_option(default_start_option), .addr(addr), .wr_en(wr_en),
	.bit_wr(bit_wr), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
	.comp_below(comp_below), .comp_on(comp_on), .comp_level(comp_level),
	.level_reserved(level_reserved), .supply_reset(supply_reset), .supply_irq(supply_irq),
	.supply_irq_mask(supply_irq_mask));
`default_nettype wire

// *** tb/svm_ctrl_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module svm_ctrl_test;
	localparam int PC = 8;
	logic        mclk, rst_n, opt, wr_en, bit_wr, rd_en, below, on, resv, srst, irq, mask, cause;
	logic        dflt;
	logic [1:0]  src;
	logic [2:0]  bsel;
	logic [3:0]  lvl;
	logic [7:0]  wdat, rdat, got;
	logic [12:0] mv;
	logic [15:0] addr;
	logic [31:0] seed = 32'h0000_2E9D;
	int          n_errors = 0, comparisons = 0, n_irq = 0, irq0, i;
	svm_ctrl #(.PULSE_CYC(PC)) svm_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .reset_source(src),
		.default_start_option(opt), .addr(addr), .wr_en(wr_en), .bit_wr(bit_wr), .bit_sel(bsel),
		.wr_data(wdat), .rd_en(rd_en), .rd_data(rdat), .comp_below(below), .comp_on(on),
		.comp_level(lvl), .level_reserved(resv), .supply_reset(srst), .supply_irq(irq),
		.supply_irq_mask(mask), .lowsupply_reset_cause(cause), .reset_by_default(dflt));
	svm_comp_model svm_comp_model_inst (.comp_on(on), .comp_level(lvl), .supply_mv(mv),
		.comp_below(below));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) if (irq === 1'b1) n_irq++;
	////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
		@(negedge mclk);
		{addr, wdat, bit_wr, bsel, wr_en} = {a, d, b, s, 1'b1};
		@(negedge mclk);
		wr_en = 1'b0;
	endtask : wr
	// Read, then sample after the data has registered
	task rd(input logic [15:0] a);
		@(negedge mclk);
		{addr, rd_en} = {a, 1'b1};
		@(negedge mclk);
		rd_en = 1'b0;
		@(negedge mclk);
		got = rdat;
	endtask : rd
	task rst(input logic [1:0] s, input logic o);
		@(negedge mclk);
		{rst_n, src, opt} = {1'b0, s, o};
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		repeat (5) @(negedge mclk);
	endtask : rst
	task stop_test;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		stop_test;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, src, opt, addr, wr_en, bit_wr, bsel, wdat, rd_en} = '0;
		mv = 13'h1388;
		rst(2'h0, 1'b0);
		chk("mask", 8'h01, {7'h00, mask});
		rd(16'hFFBE);
		chk("ctrl", 8'h00, got);
		wr(16'hFFBE, 8'h7D, 1'b0, 3'h0);
		rd(16'hFFBE);
		chk("ctrl", 8'h00, got);
		wr(16'hFFBF, 8'hF3, 1'b0, 3'h0);
		rd(16'hFFBF);
		chk("level", 8'h03, got);
		rd(16'hFFC0);
		chk("unmapped", 8'h00, got);
		wr(16'hFFBF, 8'h0B, 1'b0, 3'h0);
		chk("reserved", 8'h01, {7'h00, resv});
		// Every threshold code, supply a random step under it, then at or over it
		for (i = 0; i < 11; i++) begin
			wr(16'hFFBE, 8'h00, 1'b0, 3'h0);
			wr(16'hFFBF, i[7:0], 1'b0, 3'h0);
			wr(16'hFFBE, 8'h80, 1'b0, 3'h0);
			repeat (3) @(negedge mclk);
			irq0 = n_irq;
			mv = svm_comp_model_inst.thr(i[3:0]) - 13'(rnd() % 32'd100 + 32'd1);
			repeat (PC - 2) @(negedge mclk);
			rd(16'hFFBE);
			chk("early flag", 8'h80, got);
			repeat (8) @(negedge mclk);
			rd(16'hFFBE);
			chk("flag", 8'h81, got);
			mv = svm_comp_model_inst.thr(i[3:0]) + 13'(rnd() % 32'd100);
			repeat (4) @(negedge mclk);
			rd(16'hFFBE);
			chk("flag", 8'h80, got);
			chk("irq", 8'h02, 8'(n_irq - irq0));
		end
		// Disable by bit write while the supply is low
		mv = 13'h0960;
		repeat (PC + 6) @(negedge mclk);
		irq0 = n_irq;
		wr(16'hFFBE, 8'h00, 1'b1, 3'h7);
		repeat (3) @(negedge mclk);
		chk("irq", 8'h01, 8'(n_irq - irq0));
		rd(16'hFFBE);
		chk("ctrl", 8'h00, got);
		// Reset action, then a reset of its own kind and another
		mv = 13'h1388;
		wr(16'hFFBE, 8'h80, 1'b0, 3'h0);
		repeat (3) @(negedge mclk);
		rd(16'hFFBE);
		chk("flag", 8'h80, got);
		wr(16'hFFBE, 8'h01, 1'b1, 3'h1);
		mv = 13'h0960;
		repeat (PC + 6) @(negedge mclk);
		chk("reset", 8'h01, {7'h00, srst});
		chk("by default", 8'h00, {7'h00, dflt});
		mv = 13'h1388;
		repeat (4) @(negedge mclk);
		chk("reset", 8'h00, {7'h00, srst});
		rst(2'h1, 1'b0);
		rd(16'hFFBE);
		chk("ctrl", 8'h82, got);
		rd(16'hFFBF);
		chk("level", 8'h0A, got);
		chk("cause", 8'h01, {7'h00, cause});
		chk("mask", 8'h01, {7'h00, mask});
		rst(2'h0, 1'b0);
		rd(16'hFFBE);
		chk("ctrl", 8'h00, got);
		rd(16'hFFBF);
		chk("level", 8'h00, got);
		chk("cause", 8'h00, {7'h00, cause});
		// Default start holds reset under the fixed level
		mv = 13'h0A28;
		rst(2'h0, 1'b1);
		repeat (PC + 6) @(negedge mclk);
		chk("reset", 8'h01, {7'h00, srst});
		chk("level", 8'h0A, {4'h0, lvl});
		chk("on", 8'h01, {7'h00, on});
		chk("by default", 8'h01, {7'h00, dflt});
		chk("cause", 8'h01, {7'h00, cause});
		mv = 13'h0BB8;
		repeat (4) @(negedge mclk);
		chk("reset", 8'h00, {7'h00, srst});
		stop_test;
	end
endmodule : svm_ctrl_test
`default_nettype wire
